/* hwm_params.svh */
// offsets, field positions, reset values and masks for the monitor register bank
// assumes inclusion by bare name from the register bank and the bench
`ifndef HWM_PARAMS_SVH
`define HWM_PARAMS_SVH
`define HWM_PORT_INDEX 1'b0
`define HWM_PORT_DATA 1'b1
`define HWM_IDX_CONFIG 7'h40
`define HWM_IDX_STAT1 7'h41
`define HWM_IDX_STAT2 7'h42
`define HWM_IDX_MASK1 7'h43
`define HWM_IDX_MASK2 7'h44
`define HWM_IDX_NMASK1 7'h45
`define HWM_IDX_NMASK2 7'h46
`define HWM_IDX_VIDFAN 7'h47
`define HWM_IDX_SERADDR 7'h48
`define HWM_IDX_TMODE 7'h4c
`define HWM_IDX_OVMODE 7'h52
`define HWM_SCRATCH_LAST 7'h1f
`define HWM_VRAM_LO 7'h20
`define HWM_VRAM_HI 7'h3f
`define HWM_MIRROR_LO 7'h60
`define HWM_MIRROR_LAST 7'h7f
`define HWM_CFG_RESET 8'h01
`define HWM_NMASK2_RESET 8'h40
`define HWM_VIDFAN_RESET 4'h5
`define HWM_SERADDR_RESET 7'h2d
`define HWM_CFG_SOFTRST 7
`define HWM_CFG_TONE 6
`define HWM_CFG_IRQ_OFF 3
`define HWM_CFG_IRQ_EN 1
`define HWM_CFG_START 0
`define HWM_TMODE_BIT 6
`define HWM_OVMODE_BIT 1
`define HWM_STAT2_USED 8'h3f
`define HWM_STAT1_TEMP2 5
`define HWM_STAT2_TEMP3 5
`endif

/* hwm_pkg.sv */
// types shared by the monitor register bank
// assumes the params header sits in the same folder
package hwm_pkg;
  // one host access on the two-port window
  typedef struct packed {
    logic rd;
    logic wr;
    logic port;
    logic [7:0] wdata;
  } hwm_host_req_s;
  // comparator results for one remote sensor
  typedef struct packed {
    logic above_over;
    logic below_hyst;
  } hwm_temp_cmp_s;
  typedef enum logic [2:0] {
    HWM_OV_IDLE = 3'b001,
    HWM_OV_ACTIVE = 3'b010,
    HWM_OV_WAIT_LOW = 3'b100
  } hwm_ov_state_e;
endpackage : hwm_pkg

/* hwm_regbank.sv */
// host register window, interrupt status/mask and over-temperature outputs
// assumes host strobes and sensor comparators are on clock_i; serial bus busy is a pin
// Notes on behaviour
// - two-times mode: interrupt on over, then below hyst
// - overheat mode from index 52h bit 1
// - comparator: output held until below hysteresis
// - interrupt mode: assert on over, clear on read
// - after clear, reassert when below hysteresis
// - no reassert while still above hysteresis
// - index port: 7-bit pointer, bit 7 busy
// - busy set by index write or serial transfer
// - busy cleared by data access or transfer end
// - data port reaches the selected location
// - pairs 41h/43h/45h advance to the second register
// - scratch ram increments, stops at 1Fh
// - value ram at 20h, mirror 60h increments to 7Fh
// - config bit 7 soft reset, self clearing
// - config bit 6 drives tone pin low
// - config bit 3 masks irq, halts monitoring
// - bit 1 irq enable, bit 0 start
// - writing config zero keeps pending interrupts
// - two read-only limit status registers
// - mask one blocks matching status bit
// - reading all status clears them
// - index 4Ch bit 6 picks sensor irq mode
`timescale 1ns/1ps
`include "hwm_params.svh"
module hwm_regbank import hwm_pkg::*; #(
  parameter int RAM_WORDS = 128
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire hwm_host_req_s host_req_i,
  output logic [7:0] host_rdata_o,
  input wire logic serial_busy_i,
  input wire logic [7:0] limit_event1_i,
  input wire logic [7:0] limit_event2_i,
  input wire hwm_temp_cmp_s temp_two_cmp_i,
  input wire hwm_temp_cmp_s temp_three_cmp_i,
  input wire logic temp_reg_read_i,
  input wire logic [4:0] vid_i,
  output logic sys_mgmt_irq_n_o,
  output logic overheat_output_n_o,
  output logic tone_general_out_n_o,
  output logic monitor_run_o
);
  // the index space is seven bits wide, so the storage cannot be resized
  if (RAM_WORDS != 128) begin : g_bad_words
    $error("hwm_regbank: index space is fixed at 128");
  end

  // reset release through two flops
  logic rst_meta_n, rst_n;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // serial busy pin synchroniser; only the second flop is read
  logic sbusy_meta, sbusy;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sbusy_meta <= 1'b0;
      sbusy <= 1'b0;
    end else begin
      sbusy_meta <= serial_busy_i;
      sbusy <= sbusy_meta;
    end
  end

  logic [6:0] index_pointer;
  logic busy_host;
  logic [7:0] monitor_config, limit_status_first, limit_status_second;
  logic [7:0] irq_mask_first, irq_mask_second, nonmaskable_mask_first, nonmaskable_mask_second;
  logic [3:0] fan_div;
  logic [6:0] serial_slave_address;
  logic [7:0] ram [0:RAM_WORDS-1];
  logic temp_mode_cmp, ov_mode_b1, ov_mode_b2;
  logic stat1_read;

  wire acc_data = (host_req_i.rd | host_req_i.wr) & (host_req_i.port == `HWM_PORT_DATA);
  wire wr_data = host_req_i.wr & (host_req_i.port == `HWM_PORT_DATA);
  wire rd_data = host_req_i.rd & (host_req_i.port == `HWM_PORT_DATA);
  wire wr_index = host_req_i.wr & (host_req_i.port == `HWM_PORT_INDEX);
  wire soft_rst = wr_data & (index_pointer == `HWM_IDX_CONFIG) & host_req_i.wdata[`HWM_CFG_SOFTRST];
  wire run = monitor_config[`HWM_CFG_START] & ~monitor_config[`HWM_CFG_IRQ_OFF];

  // pointer step after a data access
  function automatic logic [6:0] next_index(input logic [6:0] idx);
    logic [6:0] r;
    r = idx;
    if (idx == `HWM_IDX_STAT1 || idx == `HWM_IDX_MASK1 || idx == `HWM_IDX_NMASK1)
      r = idx + 7'h01;
    else if (idx < `HWM_SCRATCH_LAST)
      r = idx + 7'h01;
    else if (idx >= `HWM_MIRROR_LO && idx != `HWM_MIRROR_LAST)
      r = idx + 7'h01;
    return r;
  endfunction : next_index

  // mirror folds onto the value ram words
  function automatic logic [6:0] ram_slot(input logic [6:0] idx);
    return (idx >= `HWM_MIRROR_LO) ? (idx - 7'h40) : idx;
  endfunction : ram_slot

  function automatic logic is_ram(input logic [6:0] idx);
    return (idx <= `HWM_VRAM_HI) || (idx >= `HWM_MIRROR_LO);
  endfunction : is_ram

  // index pointer
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      index_pointer <= 7'h00;
    end else if (wr_index) begin
      index_pointer <= host_req_i.wdata[6:0];
    end else if (soft_rst) begin
      index_pointer <= 7'h00;
    end else if (acc_data) begin
      index_pointer <= next_index(index_pointer);
    end
  end

  // busy from an index write ends at the next data access
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_host <= 1'b0;
    end else if (wr_index) begin
      busy_host <= 1'b1;
    end else if (acc_data) begin
      busy_host <= 1'b0;
    end
  end

  // ram storage; the host and serial master do not overlap, so no arbitration
  always_ff @(posedge clock_i) begin
    if (wr_data && is_ram(index_pointer)) begin
      ram[ram_slot(index_pointer)] <= host_req_i.wdata;
    end
  end

  // control registers; soft reset spares the serial address
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      monitor_config <= `HWM_CFG_RESET;
      irq_mask_first <= 8'h00;
      irq_mask_second <= 8'h00;
      nonmaskable_mask_first <= 8'h00;
      nonmaskable_mask_second <= `HWM_NMASK2_RESET;
      fan_div <= `HWM_VIDFAN_RESET;
      temp_mode_cmp <= 1'b0;
      ov_mode_b1 <= 1'b0;
      ov_mode_b2 <= 1'b0;
    end else if (soft_rst) begin
      monitor_config <= `HWM_CFG_RESET;
      irq_mask_first <= 8'h00;
      irq_mask_second <= 8'h00;
      nonmaskable_mask_first <= 8'h00;
      nonmaskable_mask_second <= `HWM_NMASK2_RESET;
      fan_div <= `HWM_VIDFAN_RESET;
      temp_mode_cmp <= 1'b0;
      ov_mode_b1 <= 1'b0;
      ov_mode_b2 <= 1'b0;
    end else if (wr_data) begin
      case (index_pointer)
        `HWM_IDX_CONFIG: monitor_config <= {1'b0, host_req_i.wdata[6], 2'b00, host_req_i.wdata[3], 1'b0,
                                            host_req_i.wdata[1:0]};
        `HWM_IDX_MASK1: irq_mask_first <= host_req_i.wdata;
        `HWM_IDX_MASK2: irq_mask_second <= host_req_i.wdata & `HWM_STAT2_USED;
        `HWM_IDX_NMASK1: nonmaskable_mask_first <= host_req_i.wdata;
        `HWM_IDX_NMASK2: nonmaskable_mask_second <= host_req_i.wdata;
        `HWM_IDX_VIDFAN: fan_div <= host_req_i.wdata[7:4];
        `HWM_IDX_TMODE: temp_mode_cmp <= host_req_i.wdata[`HWM_TMODE_BIT];
        // both bank copies share one index here; one write sets both to the same bit
        `HWM_IDX_OVMODE: begin
          ov_mode_b1 <= host_req_i.wdata[`HWM_OVMODE_BIT];
          ov_mode_b2 <= host_req_i.wdata[`HWM_OVMODE_BIT];
        end
        default: ;
      endcase
    end
  end

  // serial address survives soft reset
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      serial_slave_address <= `HWM_SERADDR_RESET;
    end else if (wr_data && index_pointer == `HWM_IDX_SERADDR) begin
      serial_slave_address <= host_req_i.wdata[6:0];
    end
  end

  // remote sensor irq events: comparator or two-times, per sensor
  logic t2_armed_low, t3_armed_low, t2_above_q, t3_above_q;
  wire clear_all = rd_data & (index_pointer == `HWM_IDX_STAT2) & stat1_read;
  wire t2_rise = run & temp_two_cmp_i.above_over & ~t2_above_q;
  wire t3_rise = run & temp_three_cmp_i.above_over & ~t3_above_q;
  // comparator mode re-fires while still hot; two-times fires once low after an over rise
  wire t2_evt = t2_rise | (run & temp_mode_cmp & temp_two_cmp_i.above_over & ~limit_status_first[`HWM_STAT1_TEMP2])
                | (run & ~temp_mode_cmp & t2_armed_low & temp_two_cmp_i.below_hyst);
  wire t3_evt = t3_rise | (run & temp_mode_cmp & temp_three_cmp_i.above_over & ~limit_status_second[`HWM_STAT2_TEMP3])
                | (run & ~temp_mode_cmp & t3_armed_low & temp_three_cmp_i.below_hyst);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      t2_above_q <= 1'b0;
      t3_above_q <= 1'b0;
      t2_armed_low <= 1'b0;
      t3_armed_low <= 1'b0;
    end else if (soft_rst) begin
      // stale edge history would hide a rise after a soft reset
      t2_above_q <= 1'b0;
      t3_above_q <= 1'b0;
      t2_armed_low <= 1'b0;
      t3_armed_low <= 1'b0;
    end else if (run) begin
      t2_above_q <= temp_two_cmp_i.above_over;
      t3_above_q <= temp_three_cmp_i.above_over;
      if (t2_rise) t2_armed_low <= 1'b1;
      else if (temp_two_cmp_i.below_hyst) t2_armed_low <= 1'b0;
      if (t3_rise) t3_armed_low <= 1'b1;
      else if (temp_three_cmp_i.below_hyst) t3_armed_low <= 1'b0;
    end
  end

  // status: set wins over read clear; halted monitoring leaves contents
  logic [7:0] ev1, ev2;
  always_comb begin
    ev1 = run ? limit_event1_i : 8'h00;
    ev2 = run ? (limit_event2_i & `HWM_STAT2_USED) : 8'h00;
    ev1[`HWM_STAT1_TEMP2] = t2_evt;
    ev2[`HWM_STAT2_TEMP3] = t3_evt;
  end
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      limit_status_first <= 8'h00;
      limit_status_second <= 8'h00;
      stat1_read <= 1'b0;
    end else if (soft_rst) begin
      limit_status_first <= 8'h00;
      limit_status_second <= 8'h00;
      stat1_read <= 1'b0;
    end else begin
      // config writes touch status only through soft reset
      limit_status_first <= (clear_all ? 8'h00 : limit_status_first) | ev1;
      limit_status_second <= (clear_all ? 8'h00 : limit_status_second) | ev2;
      if (rd_data && index_pointer == `HWM_IDX_STAT1) stat1_read <= 1'b1;
      else if (clear_all) stat1_read <= 1'b0;
    end
  end

  // overheat output state machine
  hwm_ov_state_e ov_state, next_ov_state;
  wire ov_cmp_mode = ~ov_mode_b1; // bit 1 zero: comparator
  wire t_over = temp_two_cmp_i.above_over | temp_three_cmp_i.above_over;
  wire t_low = temp_two_cmp_i.below_hyst & temp_three_cmp_i.below_hyst;
  always_comb begin
    next_ov_state = ov_state;
    case (ov_state)
      HWM_OV_IDLE: if (run && t_over) next_ov_state = HWM_OV_ACTIVE;
      HWM_OV_ACTIVE: begin
        if (ov_cmp_mode) begin
          if (t_low) next_ov_state = HWM_OV_IDLE;
        end else if (temp_reg_read_i) begin
          next_ov_state = t_low ? HWM_OV_IDLE : HWM_OV_WAIT_LOW;
        end
      end
      // stays quiet while still above hysteresis
      HWM_OV_WAIT_LOW: if (t_low) next_ov_state = HWM_OV_ACTIVE;
      default: next_ov_state = HWM_OV_IDLE;
    endcase
  end
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) ov_state <= HWM_OV_IDLE;
    else if (soft_rst) ov_state <= HWM_OV_IDLE;
    else ov_state <= next_ov_state;
  end

  // read mux for index and data ports
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (host_req_i.port == `HWM_PORT_INDEX) begin
      rd_mux = {busy_host | sbusy, index_pointer};
    end else if (is_ram(index_pointer)) begin
      rd_mux = ram[ram_slot(index_pointer)];
    end else begin
      case (index_pointer)
        `HWM_IDX_CONFIG: rd_mux = monitor_config;
        `HWM_IDX_STAT1: rd_mux = limit_status_first;
        `HWM_IDX_STAT2: rd_mux = limit_status_second;
        `HWM_IDX_MASK1: rd_mux = irq_mask_first;
        `HWM_IDX_MASK2: rd_mux = irq_mask_second;
        `HWM_IDX_NMASK1: rd_mux = nonmaskable_mask_first;
        `HWM_IDX_NMASK2: rd_mux = nonmaskable_mask_second;
        `HWM_IDX_VIDFAN: rd_mux = {fan_div, vid_i[3:0]};
        `HWM_IDX_SERADDR: rd_mux = {1'b0, serial_slave_address};
        `HWM_IDX_TMODE: rd_mux = {1'b0, temp_mode_cmp, 6'h00};
        `HWM_IDX_OVMODE: rd_mux = {6'h00, ov_mode_b2, 1'b0};
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // registered outputs
  wire irq_pend = |(limit_status_first & ~irq_mask_first) | |(limit_status_second & ~irq_mask_second);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata_o <= 8'h00;
      sys_mgmt_irq_n_o <= 1'b1;
      overheat_output_n_o <= 1'b1;
      tone_general_out_n_o <= 1'b1;
      monitor_run_o <= 1'b0;
    end else begin
      if (host_req_i.rd) host_rdata_o <= rd_mux;
      // once low, the pin holds while status is pending even if bit 1 drops
      sys_mgmt_irq_n_o <= ~(irq_pend & ~monitor_config[`HWM_CFG_IRQ_OFF]
                            & (monitor_config[`HWM_CFG_IRQ_EN] | ~sys_mgmt_irq_n_o));
      overheat_output_n_o <= ~(next_ov_state == HWM_OV_ACTIVE);
      tone_general_out_n_o <= ~monitor_config[`HWM_CFG_TONE];
      monitor_run_o <= run;
    end
  end

  // checks
  property p_irq_off;
    @(posedge clock_i) disable iff (!rst_n) monitor_config[`HWM_CFG_IRQ_OFF] |=> sys_mgmt_irq_n_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq driven while disabled");
  property p_irq_on;
    @(posedge clock_i) disable iff (!rst_n)
      (irq_pend && monitor_config[1] && !monitor_config[3]) |=> !sys_mgmt_irq_n_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  property p_irq_hold;
    @(posedge clock_i) disable iff (!rst_n)
      (!sys_mgmt_irq_n_o && irq_pend && !monitor_config[3]) |=> !sys_mgmt_irq_n_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped while pending");
  property p_pair;
    @(posedge clock_i) disable iff (!rst_n)
      (acc_data && !wr_index && !soft_rst && index_pointer == `HWM_IDX_MASK1) |=> index_pointer == `HWM_IDX_MASK2;
  endproperty
  a_pair: assert property (p_pair) else $error("pair advance wrong");
  property p_scr_stop;
    @(posedge clock_i) disable iff (!rst_n)
      (acc_data && !wr_index && index_pointer == `HWM_SCRATCH_LAST) |=> $stable(index_pointer);
  endproperty
  a_scr_stop: assert property (p_scr_stop) else $error("scratch pointer ran past end");
  property p_vram_fix;
    @(posedge clock_i) disable iff (!rst_n)
      (acc_data && !wr_index && index_pointer >= `HWM_VRAM_LO && index_pointer <= `HWM_VRAM_HI)
        |=> $stable(index_pointer);
  endproperty
  a_vram_fix: assert property (p_vram_fix) else $error("value ram pointer moved");
  property p_busy_set;
    @(posedge clock_i) disable iff (!rst_n) wr_index |=> busy_host;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy flag not set");
  property p_busy;
    @(posedge clock_i) disable iff (!rst_n) acc_data |=> !busy_host;
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag wrong");
  property p_tone;
    @(posedge clock_i) disable iff (!rst_n) monitor_config[6] |=> !tone_general_out_n_o;
  endproperty
  a_tone: assert property (p_tone) else $error("tone pin not low");
  property p_softrst;
    @(posedge clock_i) disable iff (!rst_n)
      soft_rst |=> (monitor_config == `HWM_CFG_RESET && irq_mask_first == 8'h00 && $stable(serial_slave_address));
  endproperty
  a_softrst: assert property (p_softrst) else $error("soft reset incomplete");
  property p_ov_wait;
    @(posedge clock_i) disable iff (!rst_n)
      (ov_state == HWM_OV_WAIT_LOW && !t_low) |=> overheat_output_n_o;
  endproperty
  a_ov_wait: assert property (p_ov_wait) else $error("overheat reasserted above hysteresis");
endmodule : hwm_regbank

/* hwm_host_model.sv */
// host processor model driving the two-port register window
// assumes one-cycle rd/wr pulses and read data valid one cycle later
`timescale 1ns/1ps
module hwm_host_model import hwm_pkg::*; (
  input wire logic clock_i,
  input wire logic [7:0] host_rdata_i,
  output hwm_host_req_s host_req_o
);
  initial host_req_o = '0;

  // one access; the bench also reads the index port while serial busy is high
  task automatic access(input logic rd, input logic wr, input logic port, input logic [7:0] wd,
                        output logic [7:0] rdata);
    @(posedge clock_i);
    #10;
    host_req_o = '{rd: rd, wr: wr, port: port, wdata: wd};
    @(posedge clock_i);
    #10;
    host_req_o = '0;
    rdata = host_rdata_i; // registered answer, taken after the edge that follows the pulse
  endtask : access
endmodule : hwm_host_model

/* hwm_regbank_tb.sv */
// self-checking bench for the monitor register bank
// assumes the host model file is compiled first
`timescale 1ns/1ps
`include "hwm_params.svh"
module hwm_regbank_tb import hwm_pkg::*; ;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic serial_busy = 1'b0;
  logic [7:0] ev1 = 8'h00;
  logic [7:0] ev2 = 8'h00;
  hwm_temp_cmp_s t2 = '0;
  hwm_temp_cmp_s t3 = '0;
  logic temp_rd = 1'b0;
  logic [4:0] vid = 5'h16;
  hwm_host_req_s req;
  logic [7:0] rdata;
  logic irq_n, ovt_n, tone_n, run;
  int fails = 0;
  int n_compared = 0;

  // 10 MHz clock
  always #50 clock_i = ~clock_i;

  hwm_host_model host (.clock_i(clock_i), .host_rdata_i(rdata), .host_req_o(req));
  hwm_regbank dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .host_req_i(req), .host_rdata_o(rdata),
    .serial_busy_i(serial_busy), .limit_event1_i(ev1), .limit_event2_i(ev2), .temp_two_cmp_i(t2),
    .temp_three_cmp_i(t3), .temp_reg_read_i(temp_rd), .vid_i(vid), .sys_mgmt_irq_n_o(irq_n),
    .overheat_output_n_o(ovt_n), .tone_general_out_n_o(tone_n), .monitor_run_o(run));

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  task automatic wr(input logic port, input logic [7:0] d);
    logic [7:0] x;
    host.access(1'b0, 1'b1, port, d, x);
  endtask : wr

  task automatic rd_chk(input logic port, input logic [7:0] exp, input string what);
    logic [7:0] v;
    host.access(1'b1, 1'b0, port, 8'h00, v);
    chk(what, exp, v);
  endtask : rd_chk

  // bounded wait on a pin; with hold set the level is watched for the full span
  task automatic pin_chk(input bit sel, input logic exp, input bit hold, input string what);
    logic v;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_i);
      #10;
      v = sel ? ovt_n : irq_n;
      if (hold && v !== exp) break;
      if (!hold && v === exp) break;
    end
    chk(what, {7'h00, exp}, {7'h00, v});
  endtask : pin_chk

  task automatic pulse(input bit which);
    @(posedge clock_i);
    #10;
    if (which) temp_rd = 1'b1;
    else ev1 = 8'h01;
    @(posedge clock_i);
    #10;
    temp_rd = 1'b0;
    ev1 = 8'h00;
  endtask : pulse

  task automatic t_reset_values;
    rd_chk(1'b0, 8'h00, "index");
    wr(1'b0, 8'h40);
    rd_chk(1'b1, 8'h01, "config");
    chk("run", 8'h01, {7'h00, run});
    wr(1'b0, 8'h46);
    rd_chk(1'b1, 8'h40, "nmask2");
    wr(1'b0, 8'h47);
    rd_chk(1'b1, {4'h5, vid[3:0]}, "vidfan");
    wr(1'b0, 8'h48);
    rd_chk(1'b1, 8'h2d, "seraddr");
    $display("test reset values done");
  endtask : t_reset_values

  task automatic t_busy_pairs;
    wr(1'b0, 8'h41);
    rd_chk(1'b0, 8'hc1, "busy after index write");
    rd_chk(1'b1, 8'h00, "status1");
    rd_chk(1'b0, 8'h42, "pointer after 41h");
    wr(1'b0, 8'h45);
    wr(1'b1, 8'h00);
    rd_chk(1'b0, 8'h46, "pointer after 45h");
    serial_busy = 1'b1;
    repeat (4) @(posedge clock_i);
    rd_chk(1'b0, 8'hc6, "serial busy");
    serial_busy = 1'b0;
    repeat (4) @(posedge clock_i);
    rd_chk(1'b0, 8'h46, "serial idle");
    $display("test busy and pairs done");
  endtask : t_busy_pairs

  task automatic t_ram;
    wr(1'b0, 8'h1e);
    wr(1'b1, 8'haa);
    wr(1'b1, 8'hbb);
    wr(1'b1, 8'hcc);
    rd_chk(1'b0, 8'h1f, "scratch stop");
    wr(1'b0, 8'h1e);
    rd_chk(1'b1, 8'haa, "scratch 1e");
    rd_chk(1'b1, 8'hcc, "scratch 1f");
    wr(1'b0, 8'h7e);
    wr(1'b1, 8'h5a);
    wr(1'b1, 8'h3c);
    rd_chk(1'b0, 8'h7f, "mirror stop");
    wr(1'b0, 8'h3e);
    rd_chk(1'b1, 8'h5a, "value ram 3e");
    rd_chk(1'b0, 8'h3e, "value ram fixed");
    $display("test ram done");
  endtask : t_ram

  task automatic t_overheat;
    t2.above_over = 1'b1;
    pin_chk(1'b1, 1'b0, 1'b0, "cmp assert");
    t2.above_over = 1'b0;
    pin_chk(1'b1, 1'b0, 1'b1, "cmp held");
    t2.below_hyst = 1'b1;
    t3.below_hyst = 1'b1;
    pin_chk(1'b1, 1'b1, 1'b0, "cmp release");
    wr(1'b0, 8'h52);
    wr(1'b1, 8'h02);
    rd_chk(1'b1, 8'h02, "overheat mode");
    t2 = '0;
    t3 = '{above_over: 1'b1, below_hyst: 1'b0};
    pin_chk(1'b1, 1'b0, 1'b0, "int assert");
    t3.above_over = 1'b0;
    pulse(1'b1);
    pin_chk(1'b1, 1'b1, 1'b0, "int cleared");
    pin_chk(1'b1, 1'b1, 1'b1, "no reassert above hyst");
    t2.below_hyst = 1'b1;
    t3.below_hyst = 1'b1;
    pin_chk(1'b1, 1'b0, 1'b0, "reassert below hyst");
    pulse(1'b1);
    pin_chk(1'b1, 1'b1, 1'b0, "second clear");
    t2 = '0;
    t3 = '0;
    $display("test overheat done");
  endtask : t_overheat

  task automatic t_tone_softreset;
    wr(1'b0, 8'h40);
    wr(1'b1, 8'h40);
    pin_chk(1'b0, 1'b1, 1'b1, "irq idle");
    chk("tone", 8'h00, {7'h00, tone_n});
    wr(1'b0, 8'h48);
    wr(1'b1, 8'h2a);
    wr(1'b0, 8'h40);
    wr(1'b1, 8'h80);
    wr(1'b0, 8'h40);
    rd_chk(1'b1, 8'h01, "config after soft reset");
    chk("tone off", 8'h01, {7'h00, tone_n});
    wr(1'b0, 8'h52);
    rd_chk(1'b1, 8'h00, "mode after soft reset");
    wr(1'b0, 8'h48);
    rd_chk(1'b1, 8'h2a, "seraddr kept");
    $display("test tone and soft reset done");
  endtask : t_tone_softreset

  task automatic t_irq;
    wr(1'b0, 8'h40);
    wr(1'b1, 8'h03);
    pulse(1'b0);
    pin_chk(1'b0, 1'b0, 1'b0, "irq raised");
    wr(1'b0, 8'h40);
    wr(1'b1, 8'h08);
    pin_chk(1'b0, 1'b1, 1'b0, "irq disabled");
    chk("run halted", 8'h00, {7'h00, run});
    wr(1'b0, 8'h40);
    wr(1'b1, 8'h03);
    pin_chk(1'b0, 1'b0, 1'b0, "status kept");
    wr(1'b0, 8'h40);
    wr(1'b1, 8'h00);
    pin_chk(1'b0, 1'b0, 1'b1, "zero config keeps pin");
    wr(1'b0, 8'h41);
    rd_chk(1'b1, 8'h01, "status1 set");
    rd_chk(1'b1, 8'h00, "status2 clear");
    pin_chk(1'b0, 1'b1, 1'b0, "irq released");
    wr(1'b0, 8'h40);
    wr(1'b1, 8'h03);
    wr(1'b0, 8'h43);
    wr(1'b1, 8'h01);
    wr(1'b1, 8'h00);
    pulse(1'b0);
    pin_chk(1'b0, 1'b1, 1'b1, "masked");
    @(posedge clock_i);
    #10;
    ev2 = 8'h01;
    @(posedge clock_i);
    #10;
    ev2 = 8'h00;
    pin_chk(1'b0, 1'b0, 1'b0, "status2 unmasked");
    wr(1'b0, 8'h41);
    rd_chk(1'b1, 8'h01, "masked bit recorded");
    rd_chk(1'b1, 8'h01, "status2 bit0");
    pin_chk(1'b0, 1'b1, 1'b0, "irq cleared");
    $display("test interrupts done");
  endtask : t_irq

  // sensor 2 status events in two-times and comparator modes
  task automatic t_sensor_irq;
    t2.above_over = 1'b1;
    pin_chk(1'b0, 1'b0, 1'b0, "over limit irq");
    t2.above_over = 1'b0;
    wr(1'b0, 8'h41);
    rd_chk(1'b1, 8'h20, "temp2 status");
    rd_chk(1'b1, 8'h00, "status2 empty");
    pin_chk(1'b0, 1'b1, 1'b1, "quiet above hyst");
    t2.below_hyst = 1'b1;
    pin_chk(1'b0, 1'b0, 1'b0, "below hyst irq");
    wr(1'b0, 8'h41);
    rd_chk(1'b1, 8'h20, "temp2 second");
    rd_chk(1'b1, 8'h00, "status2 empty again");
    pin_chk(1'b0, 1'b1, 1'b1, "no third irq");
    t2 = '0;
    wr(1'b0, 8'h4c);
    wr(1'b1, 8'h40);
    rd_chk(1'b1, 8'h40, "irq mode");
    t2.above_over = 1'b1;
    pin_chk(1'b0, 1'b0, 1'b0, "comparator irq");
    wr(1'b0, 8'h41);
    rd_chk(1'b1, 8'h20, "temp2 first");
    rd_chk(1'b1, 8'h00, "status2 quiet");
    wr(1'b0, 8'h41);
    rd_chk(1'b1, 8'h20, "temp2 refired");
    t2 = '0;
    $display("test sensor interrupts done");
  endtask : t_sensor_irq

  // watchdog cuts a hang short
  initial begin
    #5000000;
    fails++;
    close_out();
  end

  // reset for 20 cycles, then the scenarios in order
  initial begin
    repeat (20) @(posedge clock_i);
    #10;
    arst_n_i = 1'b1;
    repeat (3) @(posedge clock_i);
    t_reset_values();
    t_busy_pairs();
    t_ram();
    t_overheat();
    t_tone_softreset();
    t_irq();
    t_sensor_irq();
    close_out();
  end
endmodule : hwm_regbank_tb
